// ===== src/eeprom_pkg.sv
package eeprom_pkg;

  // density variants, also the number of page select bits
  localparam int VAR_2K      = 0;
  localparam int VAR_4K      = 1;
  localparam int VAR_8K      = 2;
  localparam int VAR_16K     = 3;
  localparam int MAX_ADDR_W  = 11;
  localparam int BYTE_W      = 8;
  localparam int STRAP_W     = 3;

  // fixed device prefix and frame bit positions
  localparam logic [3:0] DEV_PREFIX = 4'ha;
  localparam logic [3:0] BIT_LAST   = 4'h8;
  localparam int         RW_BIT     = 0;

  // self-timed write cycle: longest time, rounded down
  localparam int WR_CYCLE_MS  = 5;
  localparam int REF_CLK_KHZ  = 125000;
  localparam int WR_CYCLES_DF = WR_CYCLE_MS * REF_CLK_KHZ;

  // link engine states, gray along address and write paths and the read byte/acknowledge loop, not on ST_DEV_ACK to ST_RDATA
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_DEV     = 4'h1,
    ST_DEV_ACK = 4'h3,
    ST_WADDR   = 4'h2,
    ST_WA_ACK  = 4'h6,
    ST_WDATA   = 4'h7,
    ST_WD_ACK  = 4'h5,
    ST_RDATA   = 4'h4,
    ST_R_ACK   = 4'hc
  } link_state_t;

  // strap bits that take part in the compare for a variant
  function automatic logic [STRAP_W-1:0] strap_mask(input int variant);
    strap_mask = 3'h7 << variant;
  endfunction

  // prefix plus strap compare on a received address byte
  function automatic logic dev_match(input int variant, input logic [7:0] b,
                                     input logic [STRAP_W-1:0] strap);
    dev_match = (b[7:4] == DEV_PREFIX) &&
                (((b[3:1] ^ strap) & strap_mask(variant)) == 3'h0);
  endfunction

  // page select bits carried in the address byte
  function automatic logic [STRAP_W-1:0] page_bits(input int variant, input logic [7:0] b);
    page_bits = b[3:1] & ~strap_mask(variant);
  endfunction

endpackage

// ===== src/bit_sync.sv
`timescale 1ns/100ps
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge clk) begin
    meta_r <= d;
    q      <= meta_r;
  end

endmodule

// ===== src/eeprom_mem.sv
`timescale 1ns/100ps
module eeprom_mem #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input  wire logic              clk,
  input  wire logic              en,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata_r
);

  logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

  // single port array, read data registered
  always_ff @(posedge clk) begin
    if (en) begin
      if (we) begin
        cells[addr] <= wdata;
      end
      rdata_r <= we ? wdata : cells[addr];
    end
  end

endmodule

// ===== src/eeprom_seq_read.sv
`timescale 1ns/100ps
// Function
// RULE1: 2K: prefix 1010, bits 3..1 match the three straps, bit 0 is read/write.
// RULE2: 4K: bits 3..2 match upper straps, bit 1 is a page select bit.
// RULE3: 8K: only bit 3 matches top strap, bits 2..1 are page select.
// RULE4: 16K: straps ignored, bits 3..1 are three page select bits.
// RULE5: controller acknowledges each read byte when it wants another one.
// RULE6: on each controller acknowledge, bump word address and send next byte.
// RULE7: address wraps from top of memory to zero, streaming goes on.
// RULE8: no acknowledge then stop ends the read; data line is released.
// RULE9: write cycle starts at stop of a write sequence, lasts 5 ms at most.
// RULE10: every word is 8 bits; received words are acknowledged low on clock nine.
// RULE11: page select bits become the top bits of the following word address.
// RULE12: address mismatch gives no acknowledge and standby until next start.
// RULE13: during the write cycle the address is not acknowledged.
// RULE14: start and stop (data edge with clock high) reset bit count and state.
module eeprom_seq_read
  import eeprom_pkg::*;
#(
  parameter int VARIANT   = VAR_2K,
  parameter int WR_CYCLES = WR_CYCLES_DF
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic link_clk,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  input  wire logic strap_sel_top,
  input  wire logic strap_sel_mid,
  input  wire logic strap_sel_low
);

  localparam int ADDR_W = 8 + VARIANT;
  localparam int CNT_W  = $clog2(WR_CYCLES + 1);

  // link domain
  logic                  link_rst_n;
  logic [4:0]            pins_q;
  logic [1:0]            back_q;
  logic                  scl_q, sda_q, scl_d, sda_d;
  logic [STRAP_W-1:0]    strap_q;
  logic                  ack_s, busy_l;
  link_state_t           state_r;
  logic [3:0]            bit_cnt_r;
  logic [BYTE_W-1:0]     rx_r, tx_r, rd_word, mem_rdata;
  logic                  rw_r, mack_r, wrote_r, wc_pend_r, sda_oe_r;
  logic [STRAP_W-1:0]    page_r;
  logic [ADDR_W-1:0]     addr_r, addr_inc;
  logic [MAX_ADDR_W-1:0] waddr_full, addr_ext;
  logic                  req_tgl_r, req_we_r, wc_tgl_r;
  logic [ADDR_W-1:0]     req_addr_r;
  logic [BYTE_W-1:0]     req_data_r;
  logic                  scl_rise, scl_fall, start_ev, stop_ev;
  logic                  byte_done, dev_ok, link_busy, rd_load, req_idle;
  // reference domain
  logic [1:0]            fwd_q;
  logic                  req_seen_r, ack_tgl_r, req_new;
  logic                  wc_seen_r, wc_new, busy_r;
  logic [CNT_W-1:0]      wc_cnt_r;

  // synchronisers for reset, pins and the handshakes in both directions
  bit_sync #(.W(1)) u_lrst (.clk(link_clk), .d(rst_n), .q(link_rst_n));
  bit_sync #(.W(5)) u_pins (
    .clk (link_clk),
    .d   ({scl_i, sda_i, strap_sel_top, strap_sel_mid, strap_sel_low}),
    .q   (pins_q)
  );
  bit_sync #(.W(2)) u_back (.clk(link_clk), .d({ack_tgl_r, busy_r}), .q(back_q));
  bit_sync #(.W(2)) u_fwd (.clk(ref_clk), .d({req_tgl_r, wc_tgl_r}), .q(fwd_q));

  assign scl_q   = pins_q[4];
  assign sda_q   = pins_q[3];
  assign strap_q = pins_q[2:0];
  assign ack_s   = back_q[1];
  assign busy_l  = back_q[0];

  // delayed copies of the synchronised bus lines
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end

  // bus events and decode
  assign scl_rise   = scl_q & ~scl_d;
  assign scl_fall   = ~scl_q & scl_d;
  assign start_ev   = scl_q & scl_d & sda_d & ~sda_q;      // [RULE14]
  assign stop_ev    = scl_q & scl_d & ~sda_d & sda_q;      // [RULE14]
  assign byte_done  = scl_fall && (bit_cnt_r == BIT_LAST); // [RULE10]
  assign link_busy  = busy_l | wc_pend_r;
  assign dev_ok     = dev_match(VARIANT, rx_r, strap_q) & ~link_busy; // [RULE1] [RULE13]
  assign rd_load    = scl_fall && ((state_r == ST_DEV_ACK && rw_r) ||
                                   (state_r == ST_R_ACK && mack_r));
  assign addr_inc   = addr_r + 1'b1;                       // [RULE7]
  assign waddr_full = {page_r, rx_r};
  assign addr_ext   = MAX_ADDR_W'(addr_r);
  assign req_idle   = (ack_s == req_tgl_r);
  assign rd_word    = mem_rdata;

  // transaction state
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      state_r <= ST_IDLE;
    end else if (start_ev) begin
      state_r <= ST_DEV;                                   // [RULE14]
    end else if (stop_ev) begin
      state_r <= ST_IDLE;                                  // [RULE8]
    end else if (scl_fall) begin
      case (state_r)
        ST_DEV: begin
          if (bit_cnt_r == BIT_LAST) state_r <= dev_ok ? ST_DEV_ACK : ST_IDLE; // [RULE12]
        end
        ST_WADDR:   if (bit_cnt_r == BIT_LAST) state_r <= ST_WA_ACK;
        ST_WDATA:   if (bit_cnt_r == BIT_LAST) state_r <= ST_WD_ACK;
        ST_RDATA:   if (bit_cnt_r == BIT_LAST) state_r <= ST_R_ACK;
        ST_DEV_ACK: state_r <= rw_r ? ST_RDATA : ST_WADDR;
        ST_WA_ACK:  state_r <= ST_WDATA;
        ST_WD_ACK:  state_r <= ST_WDATA;
        ST_R_ACK:   state_r <= mack_r ? ST_RDATA : ST_IDLE; // [RULE5] [RULE8]
        default:    state_r <= ST_IDLE;
      endcase
    end
  end

  // bit counter, cleared by start/stop and at each ninth clock
  always_ff @(posedge link_clk) begin
    if (!link_rst_n || start_ev || stop_ev) begin
      bit_cnt_r <= 4'h0;                                   // [RULE14]
    end else if (scl_rise && bit_cnt_r != BIT_LAST &&
                 (state_r == ST_DEV || state_r == ST_WADDR ||
                  state_r == ST_WDATA || state_r == ST_RDATA)) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end else if (scl_fall && (state_r == ST_DEV_ACK || state_r == ST_WA_ACK ||
                              state_r == ST_WD_ACK || state_r == ST_R_ACK)) begin
      bit_cnt_r <= 4'h0;
    end
  end

  // receive shifter, direction, page bits and controller acknowledge
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      rx_r   <= 8'h00;
      rw_r   <= 1'b0;
      page_r <= 3'h0;
      mack_r <= 1'b0;
    end else begin
      if (scl_rise && bit_cnt_r != BIT_LAST) begin
        rx_r <= {rx_r[6:0], sda_q};                        // [RULE10]
      end
      if (state_r == ST_DEV && byte_done) begin
        rw_r   <= rx_r[RW_BIT];                            // [RULE1]
        page_r <= page_bits(VARIANT, rx_r);                // [RULE2] [RULE3] [RULE4]
      end
      if (start_ev) begin
        mack_r <= 1'b0;
      end else if (state_r == ST_R_ACK && scl_rise) begin
        mack_r <= ~sda_q;                                  // [RULE5]
      end
    end
  end

  // transmit shifter, loaded from the prefetched word
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      tx_r <= 8'h00;
    end else if (rd_load) begin
      tx_r <= rd_word;                                     // [RULE6]
    end else if (state_r == ST_RDATA && scl_fall && bit_cnt_r != BIT_LAST) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // open-drain data drive: acknowledges and read bits, changed on clock fall
  always_ff @(posedge link_clk) begin
    if (!link_rst_n || start_ev || stop_ev) begin
      sda_oe_r <= 1'b0;                                    // [RULE8]
    end else if (scl_fall) begin
      case (state_r)
        ST_DEV:     sda_oe_r <= (bit_cnt_r == BIT_LAST) && dev_ok; // [RULE12] [RULE13]
        ST_WADDR,
        ST_WDATA:   sda_oe_r <= (bit_cnt_r == BIT_LAST);   // [RULE10]
        ST_DEV_ACK: sda_oe_r <= rw_r & ~rd_word[7];
        ST_RDATA:   sda_oe_r <= (bit_cnt_r != BIT_LAST) & ~tx_r[6];
        ST_R_ACK:   sda_oe_r <= mack_r & ~rd_word[7];      // [RULE8]
        default:    sda_oe_r <= 1'b0;
      endcase
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_r;

  // word address counter, wraps at the top of memory
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      addr_r <= '0;
    end else if (state_r == ST_WADDR && byte_done) begin
      addr_r <= waddr_full[ADDR_W-1:0];                    // [RULE11]
    end else if ((state_r == ST_WDATA && byte_done) || rd_load) begin
      addr_r <= addr_inc;                                  // [RULE6] [RULE7]
    end
  end

  // memory requests toward the reference domain, toggle handshake
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      req_tgl_r  <= 1'b0;
      req_we_r   <= 1'b0;
      req_addr_r <= '0;
      req_data_r <= 8'h00;
    end else if (state_r == ST_DEV && byte_done && dev_ok && rx_r[RW_BIT]) begin
      req_tgl_r  <= ~req_tgl_r;
      req_we_r   <= 1'b0;
      req_addr_r <= addr_r;
    end else if (rd_load) begin
      req_tgl_r  <= ~req_tgl_r;                            // prefetch next byte
      req_we_r   <= 1'b0;
      req_addr_r <= addr_inc;                              // [RULE6]
    end else if (state_r == ST_WDATA && byte_done) begin
      req_tgl_r  <= ~req_tgl_r;
      req_we_r   <= 1'b1;
      req_addr_r <= addr_r;
      req_data_r <= rx_r;
    end
  end

  // write sequence tracking and write-cycle launch at stop
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      wrote_r   <= 1'b0;
      wc_tgl_r  <= 1'b0;
      wc_pend_r <= 1'b0;
    end else begin
      if (start_ev || stop_ev) begin
        wrote_r <= 1'b0;
      end else if (state_r == ST_WDATA && byte_done) begin
        wrote_r <= 1'b1;
      end
      if (stop_ev && wrote_r) begin
        wc_tgl_r  <= ~wc_tgl_r;                            // [RULE9]
        wc_pend_r <= 1'b1;
      end else if (busy_l) begin
        wc_pend_r <= 1'b0;
      end
    end
  end

  // reference domain: request capture and answer toggle
  assign req_new = fwd_q[1] ^ req_seen_r;
  assign wc_new  = fwd_q[0] ^ wc_seen_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req_seen_r <= 1'b0;
      ack_tgl_r  <= 1'b0;
    end else begin
      req_seen_r <= fwd_q[1];
      ack_tgl_r  <= req_seen_r;                            // answers after read data settle
    end
  end

  // array lives on the reference clock, one access per request toggle
  eeprom_mem #(.ADDR_W(ADDR_W), .DATA_W(BYTE_W)) u_mem (
    .clk     (ref_clk),
    .en      (req_new),
    .we      (req_we_r),
    .addr    (req_addr_r),
    .wdata   (req_data_r),
    .rdata_r (mem_rdata)
  );

  // self-timed write cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wc_seen_r <= 1'b0;
      busy_r    <= 1'b0;
      wc_cnt_r  <= '0;
    end else begin
      wc_seen_r <= fwd_q[0];
      if (wc_new) begin
        busy_r   <= 1'b1;                                  // [RULE9]
        wc_cnt_r <= '0;
      end else if (busy_r) begin
        if (wc_cnt_r == CNT_W'(WR_CYCLES - 1)) begin
          busy_r <= 1'b0;                                  // [RULE9]
        end
        wc_cnt_r <= wc_cnt_r + 1'b1;
      end
    end
  end

  // checks on the link engine and the reference-domain write-cycle timer
  prefix_check_a: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE1]
    (state_r == ST_DEV && byte_done && rx_r[7:4] != DEV_PREFIX) |=> !sda_oe_r)
    else $error("ack given for wrong prefix");
  strap_two_a: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE2]
    (VARIANT == VAR_4K && state_r == ST_DEV && byte_done && dev_ok)
    |-> rx_r[3:2] == strap_q[2:1])
    else $error("4K strap compare wrong");
  strap_one_a: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE3]
    (VARIANT == VAR_8K && state_r == ST_DEV && byte_done && dev_ok) |-> rx_r[3] == strap_q[2])
    else $error("8K strap compare wrong");
  strap_free_a: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE4]
    (VARIANT == VAR_16K && state_r == ST_DEV && byte_done && rx_r[7:4] == DEV_PREFIX
     && !link_busy) |=> sda_oe_r && state_r == ST_DEV_ACK)
    else $error("16K address not acknowledged");
  addr_step_a: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE6]
    (state_r == ST_R_ACK && scl_fall && mack_r && !start_ev && !stop_ev)
    |=> addr_r == $past(addr_inc) && state_r == ST_RDATA && req_addr_r == addr_r)
    else $error("read address did not step");
  addr_wrap_a: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE7]
    (rd_load && addr_r == '1 && !start_ev && !stop_ev) |=> addr_r == '0)
    else $error("address did not wrap to zero");
  stop_release_a: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE8]
    stop_ev |=> (!sda_oe_r && state_r == ST_IDLE) [*2])
    else $error("line held after stop");
  ninth_ack_a: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE10]
    (state_r == ST_WDATA && byte_done && !start_ev && !stop_ev)
    |=> sda_oe_r throughout (state_r == ST_WD_ACK && !scl_fall) [*1])
    else $error("data byte not acknowledged");
  page_top_a: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE11]
    (state_r == ST_WADDR && byte_done && !start_ev && !stop_ev)
    |=> addr_ext[10:8] == page_r && addr_r[7:0] == $past(rx_r))
    else $error("page bits not placed on top");
  mismatch_idle_a: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE12]
    (state_r == ST_DEV && byte_done && !dev_match(VARIANT, rx_r, strap_q) && !start_ev
     && !stop_ev) |=> state_r == ST_IDLE && !sda_oe_r)
    else $error("mismatch not sent to standby");
  busy_nack_a: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE13]
    (state_r == ST_DEV && byte_done && link_busy) |=> !sda_oe_r)
    else $error("address acked during write cycle");
  start_clear_a: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [RULE14]
    start_ev |=> bit_cnt_r == 4'h0 && state_r == ST_DEV && !sda_oe_r)
    else $error("start did not reset engine");
  req_gap_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    $changed(req_tgl_r) |-> $past(req_idle))
    else $error("request issued while one pending");
  wc_launch_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9]
    wc_new |=> busy_r && wc_cnt_r == '0)
    else $error("write cycle did not start");
  wc_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9]
    busy_r |-> wc_cnt_r < CNT_W'(WR_CYCLES))
    else $error("write cycle overran");

  seq_read_c: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    state_r == ST_R_ACK && scl_fall && mack_r);
  wrap_c: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    rd_load && addr_r == '1);
  busy_nack_c: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    state_r == ST_DEV && byte_done && link_busy);
  wc_done_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(busy_r));

endmodule

// ===== verification/bus_ctrl_model.sv
`timescale 1ns/100ps
module bus_ctrl_model #(
  parameter int Q = 38
) (
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_pull
);
  // bus idles with clock high and data released to the pull-up
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // one quarter bit period, moves aligned to the falling edge
  task automatic wait_q();
    repeat (Q) @(negedge clk);
  endtask

  // start or repeated start: data falls while clock is high
  task automatic start_cond();
    sda_pull = 1'b0;
    wait_q();
    scl = 1'b1;
    wait_q();
    sda_pull = 1'b1;
    wait_q();
    scl = 1'b0;
    wait_q();
  endtask

  // stop: data rises while clock is high
  task automatic stop_cond();
    sda_pull = 1'b1;
    wait_q();
    scl = 1'b1;
    wait_q();
    sda_pull = 1'b0;
    wait_q();
  endtask

  // one clock: data set in the low phase, sampled mid high phase
  task automatic clock_bit(input logic b, output logic seen);
    sda_pull = ~b;
    wait_q();
    scl = 1'b1;
    wait_q();
    seen = sda_in;
    wait_q();
    scl = 1'b0;
    wait_q();
  endtask

  // eight bits msb first, ninth clock returns the target's answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
    clock_bit(1'b1, s);
    ack = ~s;
  endtask

  // receive a byte, acknowledge only when more are wanted
  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
    clock_bit(~more, s);
  endtask
endmodule

// ===== verification/tb_serial_eeprom_addr_seq_read.sv
`timescale 1ns/100ps
module tb_serial_eeprom_addr_seq_read;
  import eeprom_pkg::*;
  localparam int WR_CYC = 3000;
  localparam int CEIL   = 90000;
  typedef struct packed {
    logic [7:0] dev;
    logic [2:0] strap;
    logic [3:0] ack;
  } row_t;

  logic       ref_clk;
  logic       link_clk;
  logic       rst_n;
  logic       scl;
  logic       sda_pull;
  logic [2:0] strap;
  logic [1:0] sel;
  logic [3:0] oe_lat;
  wire  [3:0] oe;
  wire  [3:0] o;
  wire  [3:0] sda_w;
  wire        sda_sel;
  int         n_fail = 0;
  int         n_tests = 0;
  int         cycles = 0;
  row_t       rows[6];
  logic [7:0] exp_rd[3];

  // one target per density variant, each on its own data line
  for (genvar k = 0; k < 4; k++) begin : g_var
    eeprom_seq_read #(.VARIANT(k), .WR_CYCLES(WR_CYC)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl),
      .sda_i(sda_w[k]), .sda_o(o[k]), .sda_oe(oe[k]), .strap_sel_top(strap[2]),
      .strap_sel_mid(strap[1]), .strap_sel_low(strap[0]));
    assign sda_w[k] = ~(sda_pull | (oe[k] & ~o[k]));
  end
  assign sda_sel = sda_w[sel];

  bus_ctrl_model #(.Q(38)) ctrl (
    .clk(ref_clk), .sda_in(sda_sel), .scl(scl), .sda_pull(sda_pull));

  // all targets' drive as seen at each clock rise
  always @(posedge scl) oe_lat <= oe;

  // clocks, the link one offset in phase
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #16 link_clk = ~link_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // byte to the selected target, answer compared
  task automatic put(input logic [7:0] b, input logic exp_ack, input string what);
    logic ack;
    ctrl.send_byte(b, ack);
    check(what, {7'h0, ack}, {7'h0, exp_ack});
  endtask

  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    logic [7:0] d;
    logic       ack;
    rows = '{'{8'ha6, 3'h3, 4'hf}, '{8'ha6, 3'h2, 4'he}, '{8'ha6, 3'h0, 4'hc},
             '{8'ha6, 3'h4, 4'h8}, '{8'hac, 3'h6, 4'hf}, '{8'hb6, 3'h3, 4'h0}};
    exp_rd = '{8'h11, 8'h22, 8'h33};
    rst_n = 1'b0;
    strap = 3'h0;
    sel = 2'h2;
    // held long enough for the link side too
    repeat (20) @(negedge ref_clk);
    check("drive in reset", {4'h0, oe}, 8'h00);
    rst_n = 1'b1;
    repeat (20) @(negedge ref_clk);
    // address byte decode for every variant under five strap settings
    foreach (rows[i]) begin
      strap = rows[i].strap;
      repeat (20) @(negedge ref_clk);
      ctrl.start_cond();
      ctrl.send_byte(rows[i].dev, ack);
      check("address ack", {4'h0, oe_lat}, {4'h0, rows[i].ack});
      ctrl.stop_cond();
    end
    // standby after a refused address byte
    strap = 3'h0;
    repeat (20) @(negedge ref_clk);
    ctrl.start_cond();
    put(8'hb6, 1'b0, "prefix mismatch");
    ctrl.send_byte(8'ha6, ack);
    check("standby after mismatch", {4'h0, oe_lat}, 8'h00);
    ctrl.stop_cond();
    // start in mid-byte restarts the frame
    ctrl.start_cond();
    for (int i = 0; i < 4; i++) ctrl.clock_bit(1'b1, ack);
    ctrl.start_cond();
    put(8'ha6, 1'b1, "ack after restart");
    ctrl.stop_cond();
    // two bytes at the top of the array, then busy polling
    ctrl.start_cond();
    put(8'ha6, 1'b1, "write address byte");
    put(8'hfe, 1'b1, "word address ack");
    put(8'h11, 1'b1, "data ack");
    put(8'h22, 1'b1, "data ack");
    ctrl.stop_cond();
    ctrl.start_cond();
    put(8'ha6, 1'b0, "poll during write");
    ctrl.stop_cond();
    repeat (WR_CYC + 100) @(negedge ref_clk);
    ctrl.start_cond();
    put(8'ha0, 1'b1, "poll after write");
    put(8'h00, 1'b1, "word address ack");
    put(8'h33, 1'b1, "data ack");
    ctrl.stop_cond();
    repeat (WR_CYC + 100) @(negedge ref_clk);
    // random read of the top, streaming across the wrap
    ctrl.start_cond();
    put(8'ha6, 1'b1, "dummy write");
    put(8'hfe, 1'b1, "word address ack");
    ctrl.start_cond();
    put(8'ha7, 1'b1, "read address byte");
    for (int i = 0; i < 3; i++) begin
      ctrl.recv_byte(i < 2, d);
      check("sequential byte", d, exp_rd[i]);
    end
    ctrl.stop_cond();
    repeat (20) @(negedge ref_clk);
    check("released after stop", {7'h0, oe[2]}, 8'h00);
    check("open-drain data level", {4'h0, o}, 8'h00);
    give_verdict();
  end
endmodule
